// ===== ssm_pkg.sv
package ssm_pkg;
	localparam int        SSM_WORD_BITS  = 8;
	localparam int        SSM_FIFO_DEPTH = 4;
	localparam logic [2:0] SSM_MODE_DIV4  = 3'h0;
	localparam logic [2:0] SSM_MODE_DIV16 = 3'h1;
	localparam logic [2:0] SSM_MODE_DIV64 = 3'h2;
	localparam logic [2:0] SSM_MODE_SUB   = 3'h3;
	localparam logic [2:0] SSM_MODE_TMR   = 3'h4;
	localparam logic [2:0] SSM_MODE_SLAVE = 3'h5;
	localparam logic [2:0] SSM_MODE_I2C   = 3'h6;
	localparam logic [5:0] SSM_HALF_DIV4  = 6'h01;
	localparam logic [5:0] SSM_HALF_DIV16 = 6'h07;
	localparam logic [5:0] SSM_HALF_DIV64 = 6'h1f;
	localparam logic [3:0] SSM_CNT_ZERO   = 4'h0;
	localparam logic [3:0] SSM_CNT_FULL   = 4'h8;
	typedef enum logic [1:0] {SSM_IDLE, SSM_LEAD, SSM_TRAIL} ssm_state_type;
endpackage

// ===== ssm_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module ssm_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input  wire logic             ref_clk_in,
	input  wire logic             nrst_in,
	input  wire logic [WIDTH-1:0] wr_data_in,
	input  wire logic             wr_valid_in,
	output logic                  wr_ready_out,
	output logic [WIDTH-1:0]      rd_data_out,
	output logic                  rd_valid_out,
	input  wire logic             rd_ready_in
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wp_r;
	logic [AW-1:0]    rp_r;
	logic [AW:0]      cnt_r;
	logic             push;
	logic             pop;

	assign wr_ready_out = (cnt_r != DEPTH[AW:0]);
	assign rd_valid_out = (cnt_r != '0);
	assign rd_data_out  = mem_r[rp_r];
	assign push         = wr_valid_in && wr_ready_out;
	assign pop          = rd_valid_out && rd_ready_in;

	always_ff @(posedge ref_clk_in) begin
		if (push) begin
			mem_r[wp_r] <= wr_data_in;
		end
	end

	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			if (push) begin
				wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
			end
			if (pop) begin
				rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
			end
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule
`default_nettype wire

// ===== ssm_sync.sv
`timescale 1ns/1ps
`default_nettype none
module ssm_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             ref_clk_in,
	input  wire logic             nrst_in,
	input  wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0]      sync_out
);
	logic [WIDTH-1:0] meta_r;

	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			meta_r   <= '0;
			sync_out <= '0;
		end else begin
			meta_r   <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule
`default_nettype wire

// ===== ssm_spi_port.sv
`timescale 1ns/1ps
`default_nettype none
module ssm_spi_port
	import ssm_pkg::*;
#(
	parameter int WORD_BITS  = SSM_WORD_BITS,
	parameter int FIFO_DEPTH = SSM_FIFO_DEPTH
) (
	input  wire logic                 ref_clk_in,
	input  wire logic                 nrst_in,
	// ******** Configuration ********
	input  wire logic [2:0]           serial_mode_field_in,
	input  wire logic                 uart_type_select_in,
	input  wire logic                 interface_enable_bit_in,
	input  wire logic                 pin_route_in,
	input  wire logic                 select_pin_enable_in,
	input  wire logic                 clock_idle_polarity_in,
	input  wire logic                 clock_edge_sel_in,
	input  wire logic                 lsb_first_in,
	input  wire logic                 irq_enable_in,
	input  wire logic                 sub_tick_in,
	input  wire logic                 tmr_tick_in,
	input  wire logic                 done_clear_in,
	input  wire logic                 incomplete_clear_in,
	// ******** Transmit stream ********
	input  wire logic [WORD_BITS-1:0] tx_data_in,
	input  wire logic                 tx_valid_in,
	output logic                      tx_ready_out,
	// ******** Receive stream ********
	output logic [WORD_BITS-1:0]      rx_data_out,
	output logic                      rx_valid_out,
	input  wire logic                 rx_ready_in,
	// ******** Status ********
	output logic                      transfer_done_flag_out,
	output logic                      slave_incomplete_flag_out,
	output logic                      irq_out,
	output logic                      spi_active_out,
	// ******** Pins ********
	input  wire logic                 sdi_in,
	input  wire logic                 sck_in,
	output logic                      sck_out,
	output logic                      sck_oe_n_out,
	output logic                      sdo_out,
	output logic                      sdo_oe_n_out,
	input  wire logic                 scs_n_in,
	output logic                      scs_n_out,
	output logic                      scs_oe_n_out
);
	// ******** Mode decode ********
	logic spi_sel;
	logic is_slave;
	logic is_master;
	assign spi_sel   = interface_enable_bit_in && pin_route_in && !uart_type_select_in
		&& (serial_mode_field_in <= SSM_MODE_SLAVE);
	assign is_slave  = spi_sel && (serial_mode_field_in == SSM_MODE_SLAVE);
	assign is_master = spi_sel && (serial_mode_field_in != SSM_MODE_SLAVE);

	// ******** Pin synchronisers ********
	logic [2:0] pins_s;
	logic       sdi_s;
	logic       sck_s;
	logic       scs_n_s;
	ssm_sync #(.WIDTH(3)) u_sync (
		.ref_clk_in (ref_clk_in),
		.nrst_in    (nrst_in),
		.async_in   ({sdi_in, sck_in, scs_n_in}),
		.sync_out   (pins_s)
	);
	assign sdi_s   = pins_s[2];
	assign sck_s   = pins_s[1];
	assign scs_n_s = pins_s[0];

	// ******** FIFOs ********
	logic [WORD_BITS-1:0] txq_data;
	logic                 txq_valid;
	logic                 txq_pop;
	logic [WORD_BITS-1:0] rxq_wdata_r;
	logic                 rxq_wvalid_r;
	logic                 rxq_wready;
	logic [WORD_BITS-1:0] rxq_data;
	logic                 rxq_valid;
	logic                 rx_take;
	logic                 tx_rdy;
	ssm_fifo #(.WIDTH(WORD_BITS), .DEPTH(FIFO_DEPTH)) u_txq (
		.ref_clk_in   (ref_clk_in),
		.nrst_in      (nrst_in),
		.wr_data_in   (tx_data_in),
		.wr_valid_in  (tx_valid_in),
		.wr_ready_out (tx_rdy),
		.rd_data_out  (txq_data),
		.rd_valid_out (txq_valid),
		.rd_ready_in  (txq_pop)
	);
	ssm_fifo #(.WIDTH(WORD_BITS), .DEPTH(FIFO_DEPTH)) u_rxq (
		.ref_clk_in   (ref_clk_in),
		.nrst_in      (nrst_in),
		.wr_data_in   (rxq_wdata_r),
		.wr_valid_in  (rxq_wvalid_r),
		.wr_ready_out (rxq_wready),
		.rd_data_out  (rxq_data),
		.rd_valid_out (rxq_valid),
		.rd_ready_in  (rx_take)
	);
	assign rx_take = rxq_valid && (!rx_valid_out || rx_ready_in);

	// ******** Master clock divider ********
	logic [5:0] div_r;
	logic [5:0] half_lim;
	logic       div_tick;
	logic       m_tick;
	always_comb begin
		half_lim = SSM_HALF_DIV4;
		if (serial_mode_field_in == SSM_MODE_DIV16) begin
			half_lim = SSM_HALF_DIV16;
		end else if (serial_mode_field_in == SSM_MODE_DIV64) begin
			half_lim = SSM_HALF_DIV64;
		end
	end
	assign div_tick = (div_r == half_lim);
	always_comb begin
		case (serial_mode_field_in)
			SSM_MODE_SUB: m_tick = sub_tick_in;
			SSM_MODE_TMR: m_tick = tmr_tick_in;
			default:      m_tick = div_tick;
		endcase
	end
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			div_r <= '0;
		end else if (div_tick || !is_master) begin
			div_r <= '0;
		end else begin
			div_r <= div_r + 6'h01;
		end
	end

	// ******** Slave edge detection ********
	logic sck_d_r;
	logic s_rise;
	logic s_fall;
	logic s_sel;
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			sck_d_r <= 1'b0;
		end else begin
			sck_d_r <= sck_s;
		end
	end
	assign s_rise = sck_s && !sck_d_r;
	assign s_fall = !sck_s && sck_d_r;
	assign s_sel  = !select_pin_enable_in || !scs_n_s;

	// ******** Shift engine ********
	ssm_state_type        state_r;
	logic [WORD_BITS-1:0] shift_r;
	logic [3:0]           cnt_r;
	logic                 busy_tail;
	logic                 idle_lvl;
	logic                 lead_ev;
	logic                 trail_ev;
	logic                 sample_bit;
	logic                 launch_bit;
	logic                 word_end;
	logic                 abort;
	logic                 s_lead_edge;
	logic                 s_trail_edge;
	assign idle_lvl     = !clock_idle_polarity_in;
	assign s_lead_edge  = idle_lvl ? s_fall : s_rise;
	assign s_trail_edge = idle_lvl ? s_rise : s_fall;
	assign lead_ev  = is_master ? (m_tick && state_r == SSM_LEAD)
		: (is_slave && s_sel && s_lead_edge);
	assign trail_ev = is_master ? (m_tick && state_r == SSM_TRAIL)
		: (is_slave && s_sel && s_trail_edge);
	assign sample_bit = clock_edge_sel_in ? trail_ev : lead_ev;
	assign launch_bit = clock_edge_sel_in ? lead_ev : trail_ev;
	assign word_end   = (state_r != SSM_IDLE) && trail_ev
		&& (cnt_r == SSM_CNT_FULL - 4'h1);
	assign abort      = is_slave && select_pin_enable_in && scs_n_s
		&& (state_r != SSM_IDLE) && (cnt_r != SSM_CNT_ZERO);
	assign txq_pop    = (state_r == SSM_IDLE) && txq_valid && !busy_tail
		&& (is_master ? rxq_wready : is_slave);
	assign tx_ready_out = tx_rdy;

	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state_r <= SSM_IDLE;
			cnt_r   <= SSM_CNT_ZERO;
		end else if (!spi_sel || abort) begin
			state_r <= SSM_IDLE;
			cnt_r   <= SSM_CNT_ZERO;
		end else begin
			case (state_r)
				SSM_IDLE: begin
					if (txq_pop) begin
						state_r <= SSM_LEAD;
						cnt_r   <= SSM_CNT_ZERO;
					end
				end
				SSM_LEAD: begin
					if (lead_ev) begin
						state_r <= SSM_TRAIL;
					end
				end
				SSM_TRAIL: begin
					if (trail_ev) begin
						cnt_r   <= cnt_r + 4'h1;
						state_r <= word_end ? SSM_IDLE : SSM_LEAD;
					end
				end
				default: state_r <= SSM_IDLE;
			endcase
		end
	end

	// Shifter: sample in one end, launch from the other (full duplex)
	// Master samples two cycles late to cover the pin round trip through the synchroniser
	logic       sample_pend_r;
	logic [1:0] m_samp_r;
	logic [1:0] wend_r;
	assign busy_tail = (m_samp_r != 2'h0) || (wend_r != 2'h0) || sample_pend_r
		|| rxq_wvalid_r;
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			shift_r <= '0;
		end else if (txq_pop) begin
			shift_r <= txq_data;
		end else if ((!is_master && state_r != SSM_IDLE && sample_bit) || m_samp_r[1]) begin
			if (lsb_first_in) begin
				shift_r <= {sdi_s, shift_r[WORD_BITS-1:1]};
			end else begin
				shift_r <= {shift_r[WORD_BITS-2:0], sdi_s};
			end
		end
	end
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			sample_pend_r <= 1'b0;
			m_samp_r      <= 2'h0;
			wend_r        <= 2'h0;
		end else begin
			m_samp_r      <= {m_samp_r[0], is_master && state_r != SSM_IDLE && sample_bit};
			wend_r        <= {wend_r[0], word_end};
			sample_pend_r <= wend_r[1];
		end
	end

	// ******** Pin drive ********
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			sck_out      <= 1'b1;
			sck_oe_n_out <= 1'b1;
			sdo_out      <= 1'b0;
			sdo_oe_n_out <= 1'b1;
			scs_n_out    <= 1'b1;
			scs_oe_n_out <= 1'b1;
		end else begin
			sck_out      <= (state_r == SSM_TRAIL) ? !idle_lvl : idle_lvl;
			sck_oe_n_out <= !is_master;
			sdo_out      <= lsb_first_in ? shift_r[0] : shift_r[WORD_BITS-1];
			sdo_oe_n_out <= !(is_master || (is_slave && s_sel));
			scs_n_out    <= (state_r == SSM_IDLE);
			scs_oe_n_out <= !(is_master && select_pin_enable_in);
		end
	end

	// ******** Flags and receive ********
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			transfer_done_flag_out    <= 1'b0;
			slave_incomplete_flag_out <= 1'b0;
			irq_out                   <= 1'b0;
		end else begin
			if (sample_pend_r || abort) begin
				transfer_done_flag_out <= 1'b1;
			end else if (done_clear_in) begin
				transfer_done_flag_out <= 1'b0;
			end
			if (abort) begin
				slave_incomplete_flag_out <= 1'b1;
			end else if (incomplete_clear_in) begin
				slave_incomplete_flag_out <= 1'b0;
			end
			irq_out <= irq_enable_in && (sample_pend_r || abort);
		end
	end
	always_ff @(posedge ref_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rxq_wdata_r  <= '0;
			rxq_wvalid_r <= 1'b0;
			rx_data_out  <= '0;
			rx_valid_out <= 1'b0;
			spi_active_out <= 1'b0;
		end else begin
			rxq_wvalid_r <= sample_pend_r;
			rxq_wdata_r  <= shift_r;
			if (rx_take) begin
				rx_data_out  <= rxq_data;
				rx_valid_out <= 1'b1;
			end else if (rx_ready_in) begin
				rx_valid_out <= 1'b0;
			end
			spi_active_out <= spi_sel;
		end
	end

	// ******** Checks ********
	AST_SLAVE_NO_CLK: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
		$past(is_slave) && is_slave |-> sck_oe_n_out)
		else $error("Slave drove clock");
	AST_IDLE_LEVEL: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
		$past(state_r) == SSM_IDLE && $past(clock_idle_polarity_in) |-> !sck_out)
		else $error("Clock idle level wrong");
	AST_DISABLE: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
		!interface_enable_bit_in |=> sck_oe_n_out && sdo_oe_n_out && scs_oe_n_out)
		else $error("Lines driven while disabled");
	AST_FLOAT_SEL: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
		!select_pin_enable_in |=> scs_oe_n_out)
		else $error("Select pin driven while disabled");
	AST_INCOMPLETE: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
		abort |=> slave_incomplete_flag_out && transfer_done_flag_out)
		else $error("Incomplete flags missing");
	AST_DONE: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
		word_end |-> ##4 transfer_done_flag_out)
		else $error("Done flag missing");
	AST_IRQ: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
		irq_out |-> $past(irq_enable_in))
		else $error("Interrupt without enable");
	AST_NO_SLAVE_START: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
		is_slave && state_r == SSM_LEAD |-> sck_oe_n_out || !$past(is_slave))
		else $error("Slave started clock");
	AST_SEL_HOLD: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
		is_slave && select_pin_enable_in && scs_n_s && state_r != SSM_IDLE |-> !sample_bit)
		else $error("Slave shifted while deselected");
endmodule
`default_nettype wire

// ===== ssm_peer.sv
`timescale 1ns/1ps
`default_nettype none
module ssm_peer (
	input  wire logic pol_in,
	input  wire logic edge_in,
	input  wire logic lsb_in,
	input  wire logic sck_in,
	input  wire logic sdo_in,
	output logic      sck_out,
	output logic      scs_n_out,
	output logic      sdi_out,
	output logic      drive_out
);
	logic [7:0] rply_r, got_r, mrx_r;
	logic [3:0] cnt_r;
	int         n_edges;
	time        t_first, t_last;
	logic [7:0] rxq[$];
	function automatic int pos(input int k);
		return lsb_in ? k : 7 - k;
	endfunction
	initial begin
		{drive_out, sdi_out} = 2'h0;
		{sck_out, scs_n_out} = 2'h3;
	end
	task automatic arm(input logic [7:0] r);
		rply_r = r;
		cnt_r = 4'h0;
		n_edges = 0;
		sdi_out = r[pos(0)];
	endtask
	// Slave role follows the clock it is given
	always @(sck_in) begin
		if (!drive_out && sck_in !== 1'bx) begin
			if (n_edges == 0)
				t_first = $time;
			t_last = $time;
			n_edges++;
			if ((sck_in == pol_in) != edge_in) begin
				got_r[pos(cnt_r)] = sdo_in;
				cnt_r++;
				if (cnt_r == 4'h8) begin
					rxq.push_back(got_r);
					rply_r++;
				end
			end else begin
				if (cnt_r == 4'h8)
					cnt_r = 4'h0;
				sdi_out = rply_r[pos(cnt_r)];
			end
		end
	end
	// Master role on the one select line
	task automatic xfer(input logic [7:0] d, input int nb, input logic sel);
		sck_out = ~pol_in;
		drive_out = 1;
		scs_n_out = ~sel;
		#320;
		for (int k = 0; k < nb; k++) begin
			if (!edge_in)
				sdi_out = d[pos(k)];
			#320 sck_out = pol_in;
			if (edge_in)
				sdi_out = d[pos(k)];
			else
				mrx_r[pos(k)] = sdo_in;
			#320 sck_out = ~pol_in;
			if (edge_in)
				mrx_r[pos(k)] = sdo_in;
		end
		#320 scs_n_out = 1;
		sdi_out = ~sdi_out;
		#640 drive_out = 0;
	endtask
endmodule
`default_nettype wire

// ===== test_spi_master_slave_port.sv
`timescale 1ns/1ps
`default_nettype none
module test_spi_master_slave_port;
	logic       ref_clk_in, nrst_in, uart_type_select_in, interface_enable_bit_in;
	logic       pin_route_in, select_pin_enable_in, clock_idle_polarity_in, clock_edge_sel_in;
	logic       lsb_first_in, irq_enable_in, sub_tick_in, tmr_tick_in, done_clear_in;
	logic       incomplete_clear_in, tx_valid_in, tx_ready_out, rx_valid_out, rx_ready_in;
	logic       transfer_done_flag_out, slave_incomplete_flag_out, irq_out, spi_active_out;
	logic       sdi_in, sck_out, sck_oe_n_out, sdo_out, sdo_oe_n_out, scs_n_out, scs_oe_n_out;
	logic       p_sck, p_scs_n, p_drv;
	logic [2:0] serial_mode_field_in;
	logic [7:0] tx_data_in, rx_data_out;
	logic [1:0] tick;
	wire        sck_in, scs_n_in, sdo_w;
	int         n_fail, tests_run, irq_cnt;
	initial begin
		ref_clk_in = 0;
		forever #20 ref_clk_in = ~ref_clk_in;
	end
	assign sck_in = !sck_oe_n_out ? sck_out : p_drv ? p_sck : !clock_idle_polarity_in;
	assign scs_n_in = !scs_oe_n_out ? scs_n_out : p_drv ? p_scs_n : 1'b1;
	assign sdo_w = !sdo_oe_n_out ? sdo_out : 1'bz;
	ssm_peer ssm_peer_inst (.pol_in(clock_idle_polarity_in), .edge_in(clock_edge_sel_in),
		.lsb_in(lsb_first_in), .sck_in, .sdo_in(sdo_w), .sck_out(p_sck), .scs_n_out(p_scs_n),
		.sdi_out(sdi_in), .drive_out(p_drv));
	ssm_spi_port ssm_spi_port_inst (.ref_clk_in, .nrst_in, .serial_mode_field_in,
		.uart_type_select_in, .interface_enable_bit_in, .pin_route_in, .select_pin_enable_in,
		.clock_idle_polarity_in, .clock_edge_sel_in, .lsb_first_in, .irq_enable_in, .sub_tick_in,
		.tmr_tick_in, .done_clear_in, .incomplete_clear_in, .tx_data_in, .tx_valid_in,
		.tx_ready_out, .rx_data_out, .rx_valid_out, .rx_ready_in, .transfer_done_flag_out,
		.slave_incomplete_flag_out, .irq_out, .spi_active_out, .sdi_in, .sck_in, .sck_out,
		.sck_oe_n_out, .sdo_out, .sdo_oe_n_out, .scs_n_in, .scs_n_out, .scs_oe_n_out);
	always @(posedge ref_clk_in) begin
		tick <= tick + 2'h1;
		sub_tick_in <= (tick == 2'h3);
		tmr_tick_in <= (tick == 2'h1);
		irq_cnt <= irq_cnt + int'(irq_out === 1'b1);
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic print_verdict;
		$display("Counts: %0d compared, %0d mismatched", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic cfg(input logic [2:0] m, input logic [3:0] c);
		@(posedge ref_clk_in);
		serial_mode_field_in <= m;
		{irq_enable_in, lsb_first_in, clock_edge_sel_in, clock_idle_polarity_in} <= c;
		repeat (8) @(posedge ref_clk_in);
	endtask
	task automatic clr;
		{done_clear_in, incomplete_clear_in} <= 2'h3;
		@(posedge ref_clk_in);
		{done_clear_in, incomplete_clear_in} <= 2'h0;
		repeat (2) @(posedge ref_clk_in);
	endtask
	task automatic push(input logic [7:0] d);
		tx_data_in <= d;
		tx_valid_in <= 1;
		@(posedge ref_clk_in);
		tx_valid_in <= 0;
		@(posedge ref_clk_in);
	endtask
	task automatic pop(output logic [8:0] r);
		r[8] = 0;
		for (int i = 0; i < 1500 && !r[8]; i++) begin
			@(posedge ref_clk_in);
			r = {rx_valid_out === 1'b1, rx_data_out};
		end
		rx_ready_in <= r[8];
		@(posedge ref_clk_in);
		rx_ready_in <= 0;
		repeat (3) @(posedge ref_clk_in);
	endtask
	task automatic t_master;
		int hp[5] = '{2, 8, 32, 4, 4};
		logic [7:0] d;
		logic [8:0] r;
		int i0;
		for (int m = 0; m < 5; m++)
			for (int c = 0; c < 16; c++) begin
				cfg(3'(m), 4'(c));
				chk("sck idle", sck_out, !c[0]);
				chk("master pins", {sck_oe_n_out, scs_oe_n_out, scs_n_out, spi_active_out}, 4'h3);
				d = 8'h5a ^ 8'(m * 16 + c);
				ssm_peer_inst.arm(~d);
				ssm_peer_inst.rxq.delete();
				i0 = irq_cnt;
				push(d);
				pop(r);
				chk("rx word", r, {1'b1, ~d});
				chk("peer word", ssm_peer_inst.rxq[0], d);
				chk("edges", ssm_peer_inst.n_edges, 16);
				chk("span", 32'((ssm_peer_inst.t_last - ssm_peer_inst.t_first) / 40), 15 * hp[m]);
				chk("done", transfer_done_flag_out, 1);
				chk("irq", irq_cnt - i0, c[3]);
				clr();
			end
	endtask
	task automatic t_fifo;
		int k;
		logic [8:0] r;
		cfg(3'h0, 4'h0);
		ssm_peer_inst.arm(8'ha0);
		ssm_peer_inst.rxq.delete();
		k = 0;
		tx_data_in <= 8'h10;
		tx_valid_in <= 1;
		repeat (600) begin
			@(posedge ref_clk_in);
			k += int'(tx_ready_out === 1'b1);
			tx_data_in <= 8'h10 + 8'(k);
		end
		tx_valid_in <= 0;
		chk("tx full", tx_ready_out, 0);
		for (int n = 0; n < k; n++) begin
			pop(r);
			chk("fifo rx", r, {1'b1, 8'ha0 + 8'(n)});
			chk("fifo tx", ssm_peer_inst.rxq[n], 8'h10 + 8'(n));
		end
		clr();
	endtask
	task automatic t_slave;
		logic [8:0] r;
		for (int c = 0; c < 4; c++) begin
			cfg(3'h5, 4'(c * 2));
			chk("slave pins", {sck_oe_n_out, scs_oe_n_out}, 2'h3);
			push(8'hc3 ^ 8'(c));
			ssm_peer_inst.xfer(8'h96 + 8'(c), 8, 1);
			pop(r);
			chk("slave rx", r, {1'b1, 8'h96 + 8'(c)});
			chk("slave tx", ssm_peer_inst.mrx_r, 8'hc3 ^ 8'(c));
			chk("slave done", transfer_done_flag_out, 1);
			clr();
		end
		push(8'h3c);
		ssm_peer_inst.xfer(8'h11, 8, 0);
		repeat (20) @(posedge ref_clk_in);
		chk("unselected", {transfer_done_flag_out, rx_valid_out}, 2'h0);
		ssm_peer_inst.xfer(8'h22, 4, 1);
		repeat (20) @(posedge ref_clk_in);
		chk("abort", {transfer_done_flag_out, slave_incomplete_flag_out, rx_valid_out}, 3'h6);
		clr();
		chk("cleared", {transfer_done_flag_out, slave_incomplete_flag_out}, 2'h0);
		select_pin_enable_in <= 0;
		repeat (8) @(posedge ref_clk_in);
		chk("select off", scs_oe_n_out, 1);
		push(8'h55);
		ssm_peer_inst.xfer(8'h44, 8, 0);
		pop(r);
		chk("no select rx", r, 9'h144);
		chk("no select tx", ssm_peer_inst.mrx_r, 8'h55);
	endtask
	task automatic t_off;
		logic [5:0] o[5] = '{6'h07, 6'h33, 6'h3b, 6'h01, 6'h02};
		for (int i = 0; i < 5; i++) begin
			@(posedge ref_clk_in);
			{serial_mode_field_in, uart_type_select_in, interface_enable_bit_in, pin_route_in} <= o[i];
			select_pin_enable_in <= 1;
			ssm_peer_inst.arm(8'h00);
			push(8'h77);
			repeat (200) @(posedge ref_clk_in);
			chk("off pins", {sck_oe_n_out, sdo_oe_n_out, scs_oe_n_out, spi_active_out}, 4'he);
			chk("off edges", ssm_peer_inst.n_edges, 0);
		end
	endtask
	initial begin
		{nrst_in, uart_type_select_in, clock_idle_polarity_in, clock_edge_sel_in} = 4'h0;
		{lsb_first_in, irq_enable_in, done_clear_in, incomplete_clear_in} = 4'h0;
		{tx_valid_in, rx_ready_in, sub_tick_in, tmr_tick_in} = 4'h0;
		{interface_enable_bit_in, pin_route_in, select_pin_enable_in} = 3'h7;
		{serial_mode_field_in, tick, tx_data_in} = 13'h0;
		{n_fail, tests_run, irq_cnt} = 96'h0;
		repeat (4) @(posedge ref_clk_in);
		chk("reset pins", {sck_out, sck_oe_n_out, sdo_oe_n_out, scs_oe_n_out}, 4'hf);
		chk("reset flags", {transfer_done_flag_out, slave_incomplete_flag_out, rx_valid_out}, 3'h0);
		nrst_in <= 1;
		t_master();
		$display("Test master transfers ended");
		t_fifo();
		$display("Test buffering ended");
		t_slave();
		$display("Test slave transfers ended");
		t_off();
		$display("Test disabled port ended");
		print_verdict();
	end
	initial begin
		repeat (60000) @(posedge ref_clk_in);
		n_fail++;
		print_verdict();
	end
endmodule
`default_nettype wire
